// file: rtl/sfdpr_param_rom.sv
/*
 * Parameter table reader: maps a CFI-relative or SFDP address onto the
 * table, fetches bytes in order and shifts them out MSB first.
 * Assumes requests come from logic on sys_clk, so no input synchroniser.
 */
`timescale 1ns/1ps
`include "sfdpr_cfg.svh"
module sfdpr_param_rom
    import sfdpr_pkg::*;
#(
    parameter bit DDR_VARIANT = 1'b0
) (
    input wire sys_clk,
    input wire rst_n,
    input wire rd_start,
    input wire rd_space,
    input wire [15:0] rd_addr,
    input wire byte_req,
    input wire bit_tick,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic rd_hit,
    output logic past_fixed,
    output logic ser_dout,
    output logic bit_last
);
    sfdpr_rom_if rom_bus ();

    sfdpr_state_t state_r;
    sfdpr_state_t state_nxt;
    sfdpr_addr_t idx_r;
    sfdpr_addr_t idx_nxt;
    sfdpr_addr_t start_idx;
    sfdpr_byte_t data_r;
    sfdpr_byte_t data_nxt;
    sfdpr_byte_t shift_r;
    sfdpr_byte_t shift_nxt;
    logic [2:0] bit_cnt_r;
    logic [2:0] bit_cnt_nxt;
    logic valid_r;
    logic valid_nxt;
    logic hit_r;
    logic hit_nxt;
    logic past_r;
    logic past_nxt;
    logic ser_r;
    logic ser_nxt;
    logic last_r;
    logic last_nxt;
    logic advance;
    logic in_table;

    sfdpr_rom #(
        .DDR_VARIANT(DDR_VARIANT)
    ) u_rom (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rom(rom_bus.store)
    );

    // sfdp addresses sit two below the cfi offsets of the same byte
    always_comb begin
        if (!rd_space) begin
            start_idx = rd_addr;
        end else if (rd_addr >= (`SFDPR_BASIC_BASE - `SFDPR_CFI_SKEW)) begin
            start_idx = rd_addr - (`SFDPR_BASIC_BASE - `SFDPR_CFI_SKEW);
        end else begin
            start_idx = `SFDPR_IDX_OUT;
        end
    end

    assign in_table = (idx_r < `SFDPR_TBL_LEN);
    // a full shifted byte counts as a request for the next one
    assign advance = byte_req || (bit_tick && (bit_cnt_r == `SFDPR_BITS_LAST));

    assign rom_bus.rd_en = (state_r == SFDPR_FETCH) && in_table;
    assign rom_bus.idx = idx_r[4:0];

    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        if (rd_start) begin
            // a new start wins over any byte in flight
            state_nxt = SFDPR_FETCH;
            idx_nxt = start_idx;
        end else begin
            case (state_r)
                SFDPR_IDLE: state_nxt = SFDPR_IDLE;
                SFDPR_FETCH: state_nxt = SFDPR_CAPT;
                SFDPR_CAPT: state_nxt = SFDPR_HOLD;
                SFDPR_HOLD: begin
                    if (advance) begin
                        state_nxt = SFDPR_FETCH;
                        if (idx_r != `SFDPR_IDX_OUT) begin
                            idx_nxt = idx_r + 16'h0001;
                        end
                    end
                end
                default: state_nxt = SFDPR_IDLE;
            endcase
        end
    end

    always_comb begin
        data_nxt = data_r;
        valid_nxt = 1'b0;
        hit_nxt = hit_r;
        past_nxt = past_r;
        shift_nxt = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        ser_nxt = ser_r;
        last_nxt = 1'b0;
        if (state_r == SFDPR_CAPT && !rd_start) begin
            // beyond this table the run continues elsewhere; fill bytes here
            data_nxt = in_table ? rom_bus.data : `SFDPR_FILL;
            hit_nxt = in_table;
            // the sector map starts right after the fixed tables
            past_nxt = (idx_r != `SFDPR_IDX_OUT) && (idx_r >= `SFDPR_FIXED_LEN);
            valid_nxt = 1'b1;
            shift_nxt = data_nxt;
            bit_cnt_nxt = 3'h0;
            ser_nxt = data_nxt[7];
        end else if (state_r == SFDPR_HOLD && !rd_start && !advance) begin
            valid_nxt = 1'b1;
            if (bit_tick) begin
                shift_nxt = {shift_r[6:0], 1'b1};
                bit_cnt_nxt = bit_cnt_r + 3'h1;
                ser_nxt = shift_r[6];
                last_nxt = (bit_cnt_nxt == `SFDPR_BITS_LAST);
            end else begin
                last_nxt = last_r;
            end
        end else if (rd_start) begin
            hit_nxt = 1'b0;
            past_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= SFDPR_IDLE;
            idx_r <= 16'h0000;
            data_r <= `SFDPR_FILL;
            valid_r <= 1'b0;
            hit_r <= 1'b0;
            past_r <= 1'b0;
            shift_r <= `SFDPR_FILL;
            bit_cnt_r <= 3'h0;
            ser_r <= 1'b1;
            last_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            data_r <= data_nxt;
            valid_r <= valid_nxt;
            hit_r <= hit_nxt;
            past_r <= past_nxt;
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            ser_r <= ser_nxt;
            last_r <= last_nxt;
        end
    end

    assign rd_data = data_r;
    assign rd_valid = valid_r;
    assign rd_hit = hit_r;
    assign past_fixed = past_r;
    assign ser_dout = ser_r;
    assign bit_last = last_r;
endmodule

// file: rtl/sfdpr_cfg.svh
/*
 * Constants of the discoverable-parameter byte table: CFI header bytes
 * and the first four dwords of the basic flash parameter table.
 * Assumes inclusion by bare name from the rtl files; definitions only.
 */
// Notes on behaviour
// - identifier byte A5h at relative offset zero
// - length byte 88h, 136 following bytes
// - basic table starts at address 1090h
// - byte zero E7h, top ones, big buffer
// - bits 4:3 zero, 06h write enable, nonvolatile
// - no uniform 4-KB erase, opcode FFh
// - third byte B2h, or BAh with DDR
// - quad and dual I/O yes, outputs no
// - address bytes field 01b, three or four
// - density 1FFFFFFFh, least significant byte first
// - quad I/O cycles byte 48h
// - quad I/O opcode EBh follows
// - quad-output cycles and opcode all ones
// - dual-output cycles and opcode all ones
// - dual I/O cycles byte 88h
// - dual I/O opcode BBh follows
// - top byte of dword one FFh
// - one contiguous run, CFI offset two above
// - sector map follows fixed tables directly
`ifndef SFDPR_CFG_SVH
`define SFDPR_CFG_SVH

`define SFDPR_BASIC_BASE 16'h1090
`define SFDPR_CFI_SKEW 16'h0002
`define SFDPR_TBL_LEN 16'h0012
`define SFDPR_FIXED_LEN 16'h0088
`define SFDPR_IDX_OUT 16'hFFFF
`define SFDPR_BITS_LAST 3'h7

`define SFDPR_IDX_ID 5'h00
`define SFDPR_IDX_LEN 5'h01
`define SFDPR_IDX_DW1_B0 5'h02
`define SFDPR_IDX_DW1_B1 5'h03
`define SFDPR_IDX_DW1_B2 5'h04
`define SFDPR_IDX_DW1_B3 5'h05
`define SFDPR_IDX_DW2_B0 5'h06
`define SFDPR_IDX_DW2_B1 5'h07
`define SFDPR_IDX_DW2_B2 5'h08
`define SFDPR_IDX_DW2_B3 5'h09
`define SFDPR_IDX_QIO_CYC 5'h0A
`define SFDPR_IDX_QIO_OP 5'h0B
`define SFDPR_IDX_QO_CYC 5'h0C
`define SFDPR_IDX_QO_OP 5'h0D
`define SFDPR_IDX_DO_CYC 5'h0E
`define SFDPR_IDX_DO_OP 5'h0F
`define SFDPR_IDX_DIO_CYC 5'h10
`define SFDPR_IDX_DIO_OP 5'h11

`define SFDPR_ID 8'hA5
`define SFDPR_LEN 8'h88
`define SFDPR_FILL 8'hFF
`define SFDPR_B0_UNUSED 3'h7
`define SFDPR_B0_WREN 2'h0
`define SFDPR_B0_BIGBUF 1'h1
`define SFDPR_B0_NO4K 2'h3
`define SFDPR_4K_OP 8'hFF
`define SFDPR_DENSITY 32'h1FFFFFFF
`define SFDPR_ADDR_BYTES 2'h1
`define SFDPR_QIO_MODE 3'h2
`define SFDPR_QIO_DUMMY 5'h08
`define SFDPR_QIO_OP 8'hEB
`define SFDPR_ABSENT_MODE 3'h7
`define SFDPR_ABSENT_DUMMY 5'h1F
`define SFDPR_ABSENT_OP 8'hFF
`define SFDPR_DIO_MODE 3'h4
`define SFDPR_DIO_DUMMY 5'h08
`define SFDPR_DIO_OP 8'hBB

`endif

// file: rtl/sfdpr_pkg.sv
/*
 * Types shared by the parameter table reader and its byte store.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sfdpr_pkg;
    typedef logic [7:0] sfdpr_byte_t;
    typedef logic [4:0] sfdpr_idx_t;
    typedef logic [15:0] sfdpr_addr_t;
    typedef enum logic [1:0] {
        SFDPR_IDLE,
        SFDPR_FETCH,
        SFDPR_CAPT,
        SFDPR_HOLD
    } sfdpr_state_t;
endpackage

// file: rtl/sfdpr_rom_if.sv
/*
 * Read port between the table reader and the byte store.
 * Assumes both ends run on sys_clk; read data lag the request by one edge.
 */
`timescale 1ns/1ps
interface sfdpr_rom_if;
    import sfdpr_pkg::*;
    logic rd_en;
    sfdpr_idx_t idx;
    sfdpr_byte_t data;
    modport reader (output rd_en, output idx, input data);
    modport store (input rd_en, input idx, output data);
endinterface

// file: rtl/sfdpr_rom.sv
/*
 * Byte store of the parameter table, read data from a register.
 * Assumes one read per rd_en; idx beyond the table returns fill bytes.
 */
`timescale 1ns/1ps
`include "sfdpr_cfg.svh"
module sfdpr_rom
    import sfdpr_pkg::*;
#(
    parameter bit DDR_VARIANT = 1'b0
) (
    input wire sys_clk,
    input wire rst_n,
    sfdpr_rom_if.store rom
);
    sfdpr_byte_t data_r;
    sfdpr_byte_t data_nxt;
    sfdpr_byte_t dw1_b0;
    sfdpr_byte_t dw1_b2;
    logic [31:0] density;

    always_comb begin
        dw1_b0 = {`SFDPR_B0_UNUSED, `SFDPR_B0_WREN, `SFDPR_B0_BIGBUF, `SFDPR_B0_NO4K};
        // unused, quad out, quad io, dual io, ddr, address bytes, dual out
        dw1_b2 = {1'b1, 1'b0, 1'b1, 1'b1, DDR_VARIANT, `SFDPR_ADDR_BYTES, 1'b0};
        density = `SFDPR_DENSITY;
        data_nxt = data_r;
        if (rom.rd_en) begin
            case (rom.idx)
                `SFDPR_IDX_ID: data_nxt = `SFDPR_ID;
                `SFDPR_IDX_LEN: data_nxt = `SFDPR_LEN;
                `SFDPR_IDX_DW1_B0: data_nxt = dw1_b0;
                `SFDPR_IDX_DW1_B1: data_nxt = `SFDPR_4K_OP;
                `SFDPR_IDX_DW1_B2: data_nxt = dw1_b2;
                `SFDPR_IDX_DW1_B3: data_nxt = `SFDPR_FILL;
                `SFDPR_IDX_DW2_B0: data_nxt = density[7:0];
                `SFDPR_IDX_DW2_B1: data_nxt = density[15:8];
                `SFDPR_IDX_DW2_B2: data_nxt = density[23:16];
                `SFDPR_IDX_DW2_B3: data_nxt = density[31:24];
                `SFDPR_IDX_QIO_CYC: data_nxt = {`SFDPR_QIO_MODE, `SFDPR_QIO_DUMMY};
                `SFDPR_IDX_QIO_OP: data_nxt = `SFDPR_QIO_OP;
                `SFDPR_IDX_QO_CYC: data_nxt = {`SFDPR_ABSENT_MODE, `SFDPR_ABSENT_DUMMY};
                `SFDPR_IDX_QO_OP: data_nxt = `SFDPR_ABSENT_OP;
                `SFDPR_IDX_DO_CYC: data_nxt = {`SFDPR_ABSENT_MODE, `SFDPR_ABSENT_DUMMY};
                `SFDPR_IDX_DO_OP: data_nxt = `SFDPR_ABSENT_OP;
                `SFDPR_IDX_DIO_CYC: data_nxt = {`SFDPR_DIO_MODE, `SFDPR_DIO_DUMMY};
                `SFDPR_IDX_DIO_OP: data_nxt = `SFDPR_DIO_OP;
                default: data_nxt = `SFDPR_FILL;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            data_r <= `SFDPR_FILL;
        end else begin
            data_r <= data_nxt;
        end
    end

    assign rom.data = data_r;
endmodule

// file: sim/sfdpr_assertions.sv
/* Port checker for the parameter reader.
 * Bound from the bench top; one clock domain. */
`timescale 1ns/1ps
module sfdpr_assertions (
    input wire sys_clk,
    input wire rst_n,
    input wire rd_start,
    input wire rd_space,
    input wire [15:0] rd_addr,
    input wire byte_req,
    input wire bit_tick,
    input wire [7:0] rd_data,
    input wire rd_valid,
    input wire rd_hit,
    input wire past_fixed,
    input wire ser_dout,
    input wire bit_last
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // answer is sampled at the third edge after the start, before any advance lands
    property p_byte(bit sp, logic [15:0] a, logic [7:0] d);
        rd_start && rd_space == sp && rd_addr == a ##1 !rd_start [*2]
            |-> ##1 rd_valid && rd_hit && rd_data == d;
    endproperty
    a_id_byte: assert property (p_byte(0, 16'h0000, 8'hA5)) else $error("id");
    a_len_byte: assert property (p_byte(0, 16'h0001, 8'h88)) else $error("len");
    a_sfdp_base: assert property (p_byte(1, 16'h1090, 8'hE7)) else $error("base");
    a_qio_op: assert property (p_byte(0, 16'h000B, 8'hEB)) else $error("qio");
    a_adv_drop: assert property (byte_req && rd_valid && !rd_start |=> !rd_valid)
        else $error("no drop");
    a_adv_back: assert property (byte_req && rd_valid && !rd_start ##1 !rd_start [*2]
        |-> ##1 rd_valid) else $error("no return");
    a_hold_data: assert property (rd_valid && !rd_start && !byte_req && !bit_tick
        |=> rd_valid && $stable(rd_data)) else $error("unstable");
    a_fill_beyond: assert property (rd_valid && past_fixed |-> !rd_hit && rd_data == 8'hFF)
        else $error("fill");
    a_serial_msb: assert property ($rose(rd_valid) |-> ser_dout == rd_data[7] && !bit_last)
        else $error("msb");
    c_serial: cover property (bit_last && bit_tick);
    c_beyond: cover property (rd_valid && past_fixed);
    c_sfdp: cover property (rd_start && rd_space);
endmodule

// file: sim/sfdpr_host_model.sv
/* Host side: issues starts and advances to the reader.
 * Assumes the caller waits for reset release first. */
`timescale 1ns/1ps
module sfdpr_host_model (
    input wire sys_clk,
    input wire rd_valid,
    output logic rd_start,
    output logic rd_space,
    output logic [15:0] rd_addr,
    output logic byte_req,
    output logic bit_tick
);
    initial begin
        rd_start = 1'h0;
        rd_space = 1'h0;
        rd_addr = 16'h0000;
        byte_req = 1'h0;
        bit_tick = 1'h0;
    end
    // bounded so a dead reader cannot hang the host
    task automatic wait_valid();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (!rd_valid && n < 20);
    endtask
    task automatic start(input logic sp, input logic [15:0] a);
        @(posedge sys_clk);
        rd_start <= 1'h1;
        rd_space <= sp;
        rd_addr <= a;
        @(posedge sys_clk);
        rd_start <= 1'h0;
        wait_valid();
    endtask
    task automatic step(input logic tick, input logic wt);
        @(posedge sys_clk);
        bit_tick <= tick;
        byte_req <= !tick;
        @(posedge sys_clk);
        bit_tick <= 1'h0;
        byte_req <= 1'h0;
        #1;
        if (wt)
            wait_valid();
    endtask
endmodule

// file: sim/tb_sfdp_basic_parameter_rom.sv
/* Bench top: host model drives the reader, a monitor checks bytes.
 * Assumes the rtl files are compiled first. */
`timescale 1ns/1ps
module tb_sfdp_basic_parameter_rom;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic rd_start, rd_space, byte_req, bit_tick, rd_valid, rd_hit;
    logic past_fixed, ser_dout, bit_last;
    logic prev_valid = 1'h0;
    logic [15:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] ddr_data;
    logic [7:0] rnd;
    logic [9:0] exp_q[$];
    int mismatches = 0;
    int n_compared = 0;
    localparam logic [7:0] TBL [18] = '{8'hA5, 8'h88,
        8'hE7, 8'hFF, 8'hB2, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'h1F,
        8'h48, 8'hEB, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h88, 8'hBB};
    always #25 sys_clk = ~sys_clk;
    sfdpr_host_model host (.sys_clk(sys_clk), .rd_valid(rd_valid), .rd_start(rd_start),
        .rd_space(rd_space), .rd_addr(rd_addr), .byte_req(byte_req), .bit_tick(bit_tick));
    sfdpr_param_rom #(.DDR_VARIANT(1'h0)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .rd_start(rd_start), .rd_space(rd_space), .rd_addr(rd_addr), .byte_req(byte_req),
        .bit_tick(bit_tick), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit),
        .past_fixed(past_fixed), .ser_dout(ser_dout), .bit_last(bit_last));
    // ddr variant follows the same host in lockstep; only its feature byte differs
    sfdpr_param_rom #(.DDR_VARIANT(1'h1)) DUT_DDR (.sys_clk(sys_clk), .rst_n(rst_n),
        .rd_start(rd_start), .rd_space(rd_space), .rd_addr(rd_addr), .byte_req(byte_req),
        .bit_tick(bit_tick), .rd_data(ddr_data), .rd_valid(), .rd_hit(),
        .past_fixed(), .ser_dout(), .bit_last());
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // CFI offset in; packed as past_fixed, hit, data
    task automatic note(input logic [15:0] a);
        exp_q.push_back({a >= 16'h0088, a < 16'h0012, a < 16'h0012 ? TBL[a[4:0]] : 8'hFF});
    endtask
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        prev_valid <= rd_valid;
        if (rst_n && rd_valid && !prev_valid)
            check("byte", {past_fixed, rd_hit, rd_data}, exp_q.size() ? exp_q.pop_front() : 'x);
    end
    initial begin
        int i;
        rnd = 8'h30;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'h1;
        note(16'h0000);
        host.start(1'h0, 16'h0000);
        // runs one past the table end into fill
        for (i = 1; i < 19; i++) begin
            note(16'(i));
            host.step(1'h0, 1'h1);
            if (i == 4)
                check("ddr_byte", {2'h0, ddr_data}, 10'h0BA);
        end
        $display("test cfi_walk done");
        note(16'h0002);
        host.start(1'h1, 16'h1090);
        note(16'h0003);
        host.step(1'h0, 1'h1);
        $display("test sfdp_map done");
        note(16'h000B);
        host.start(1'h0, 16'h000B);
        for (i = 7; i >= 0; i--) begin
            check("ser_dout", {9'h000, ser_dout}, {9'h000, TBL[11][i]});
            check("bit_last", {9'h000, bit_last}, {9'h000, i == 0});
            if (i > 0)
                host.step(1'h1, 1'h0);
        end
        note(16'h000C);
        host.step(1'h1, 1'h1);
        $display("test serial done");
        note(16'h0087);
        host.start(1'h0, 16'h0087);
        note(16'h0088);
        host.step(1'h0, 1'h1);
        $display("test boundary done");
        // restarts land while the previous byte still stands
        for (i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            note({11'h000, rnd[4:0]});
            host.start(1'h0, {11'h000, rnd[4:0]});
        end
        $display("test random done");
        repeat (4) @(posedge sys_clk);
        check("queue", 10'(exp_q.size()), 10'h000);
        stop_test();
    end
    initial begin
        #400000;
        mismatches++;
        stop_test();
    end
endmodule
bind sfdpr_param_rom sfdpr_assertions u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .rd_start(rd_start), .rd_space(rd_space), .rd_addr(rd_addr), .byte_req(byte_req),
    .bit_tick(bit_tick), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit),
    .past_fixed(past_fixed), .ser_dout(ser_dout), .bit_last(bit_last));
